// ---- three_source_interrupt_ctrl.sv ----
`timescale 1ns/1ns
`include "icu_regs.svh"
// Functional notes
// - three internal sources only: counter, over-current, periodic tick.
// - control bits 6,5,4 are tick, counter, over-current request flags.
// - control bits 3,2,1 are tick, counter, over-current enables.
// - bit 0 is global enable; bit 7 always reads zero.
// - a source event sets its flag regardless of any enable.
// - disabled source keeps its flag but never vectors.
// - global enable low blocks every interrupt.
// - taking pushes next address and loads the source vector.
// - every source owns a distinct vector address.
// - servicing any interrupt clears the global enable.
// - events during servicing still set their flags.
// - full return stack blocks acknowledging any request.
// - return from interrupt pops saved address and resumes there.
// - simultaneous requests resolved by fixed priority.
// - any flag rising from low to high wakes the device from sleep or idle.
// - over-current detector report sets the over-current flag.
// - over-current vector needs global, own enable, stack room, flag.
// - servicing over-current clears its flag and the global enable.
// - counter overflow sets its flag; servicing clears it.
// - tick overflow sets its flag; servicing clears it.
// - return from interrupt also sets global enable; plain return not.
// - wake only on a flag's low-to-high change, enables ignored.

module three_source_interrupt_ctrl import icu_pkg::*; (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic REG_WR_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	input wire logic COUNTER_OVF_I,
	input wire logic TICK_OVF_I,
	input wire logic OVERCURRENT_I,
	input wire logic INSTR_BOUNDARY_I,
	input wire logic STACK_FULL_I,
	input wire logic [`ICU_PC_W-1:0] NEXT_PC_I,
	input wire logic [`ICU_PC_W-1:0] STACKED_PC_I,
	input wire logic RET_I,
	input wire logic RETURN_FROM_INTERRUPT_INSTR_I,
	output logic IRQ_PENDING_O,
	output logic STACK_PUSH_O,
	output logic [`ICU_PC_W-1:0] STACK_PUSH_DATA_O,
	output logic STACK_POP_O,
	output logic PC_LOAD_O,
	output logic [`ICU_PC_W-1:0] PC_VALUE_O,
	output logic WAKE_O
);
	src_vec_t flag_r;
	src_vec_t flag_nxt;
	src_vec_t flag_prev_r;
	src_vec_t en_r;
	src_vec_t src_evt;
	logic global_irq_enable_r;
	logic global_irq_enable_nxt;
	logic ovc_s1_r;
	logic ovc_s2_r;
	logic ovc_s3_r;
	logic ovc_rise;
	logic take;
	logic ret_take;
	logic wake_r;
	pc_t pc_value_r;
	pc_t push_data_r;
	ctl_state_t state_r;
	ctl_state_t state_nxt;

	irq_arb_if arb_bus();

	irq_arbiter u_arb (
		.bus(arb_bus.arb)
	);

	// detector is analog-side, so it is synchronised before use
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ovc_s1_r <= 1'b0;
			ovc_s2_r <= 1'b0;
			ovc_s3_r <= 1'b0;
		end else begin
			ovc_s1_r <= OVERCURRENT_I;
			ovc_s2_r <= ovc_s1_r;
			ovc_s3_r <= ovc_s2_r;
		end
	end

	// edge, not level: a held condition would defeat a software clear
	assign ovc_rise = ovc_s2_r & ~ovc_s3_r;

	assign src_evt[`ICU_SRC_OVC] = ovc_rise;
	assign src_evt[`ICU_SRC_CNT] = COUNTER_OVF_I;
	assign src_evt[`ICU_SRC_TICK] = TICK_OVF_I;

	// enabled pending requests go to the arbiter
	assign arb_bus.pending = flag_r & en_r;

	assign IRQ_PENDING_O = global_irq_enable_r & arb_bus.any
		& ~STACK_FULL_I;
	assign ret_take = (RET_I | RETURN_FROM_INTERRUPT_INSTR_I)
		& (state_r == ST_IDLE);
	// a return in the same boundary goes first; the request stays pending
	assign take = IRQ_PENDING_O & INSTR_BOUNDARY_I & (state_r == ST_IDLE)
		& ~ret_take;

	genvar i;
	generate
		for (i = 0; i < `ICU_NUM_SRC; i = i + 1) begin : g_flag
			// hardware set beats both the service clear and a write
			always_comb begin
				if (src_evt[i]) begin
					flag_nxt[i] = 1'b1;
				end else if (take && arb_bus.grant[i]) begin
					flag_nxt[i] = 1'b0;
				end else if (REG_WR_I) begin
					flag_nxt[i] = REG_WDATA_I[`ICU_FLAG_LSB+i];
				end else begin
					flag_nxt[i] = flag_r[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			flag_r <= '0;
			flag_prev_r <= '0;
		end else begin
			flag_r <= flag_nxt;
			flag_prev_r <= flag_r;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			en_r <= '0;
		end else if (REG_WR_I) begin
			en_r <= REG_WDATA_I[`ICU_EN_LSB +: `ICU_NUM_SRC];
		end
	end

	always_comb begin
		global_irq_enable_nxt = global_irq_enable_r;
		if (REG_WR_I) begin
			global_irq_enable_nxt =
				REG_WDATA_I[`ICU_BIT_GLOBAL_EN];
		end
		if (take) begin
			global_irq_enable_nxt = 1'b0;
		end else if (ret_take && RETURN_FROM_INTERRUPT_INSTR_I) begin
			global_irq_enable_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			global_irq_enable_r <= 1'b0;
		end else begin
			global_irq_enable_r <= global_irq_enable_nxt;
		end
	end

	// bit 7 is not stored at all
	assign REG_RDATA_O = {1'b0, flag_r, en_r,
		global_irq_enable_r};

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (ret_take) begin
					state_nxt = ST_RETURN;
				end else if (take) begin
					state_nxt = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				state_nxt = ST_IDLE;
			end
			ST_RETURN: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			pc_value_r <= '0;
			push_data_r <= '0;
		end else if (ret_take) begin
			pc_value_r <= STACKED_PC_I;
		end else if (take) begin
			pc_value_r <= arb_bus.vector;
			push_data_r <= NEXT_PC_I;
		end
	end

	assign STACK_PUSH_O = (state_r == ST_ENTRY);
	assign STACK_POP_O = (state_r == ST_RETURN);
	assign PC_LOAD_O = (state_r != ST_IDLE);
	assign STACK_PUSH_DATA_O = push_data_r;
	assign PC_VALUE_O = pc_value_r;

	// a flag already high gives no wake, which lets software mask it
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= |(flag_r & ~flag_prev_r);
		end
	end

	assign WAKE_O = wake_r;

	AST_GLOBAL_GATE: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		!global_irq_enable_r |=> !STACK_PUSH_O)
		else $error("interrupt entered with global enable low");

	AST_FULL_BLOCK: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		STACK_FULL_I |=> !STACK_PUSH_O)
		else $error("interrupt entered with stack full");

	AST_GLOBAL_CLEARED: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		STACK_PUSH_O |-> !global_irq_enable_r && PC_LOAD_O)
		else $error("global enable not cleared on entry");

	AST_FLAG_SET: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		COUNTER_OVF_I |=> flag_r[`ICU_SRC_CNT])
		else $error("counter event did not set its flag");

	AST_OVC_VECTOR: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.pending[`ICU_SRC_OVC] && !ovc_rise |=>
		PC_VALUE_O == `ICU_VEC_OVC && !flag_r[`ICU_SRC_OVC])
		else $error("over-current entry wrong vector or flag kept");

	AST_CNT_PRIO: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.pending[`ICU_SRC_CNT]
		&& !arb_bus.pending[`ICU_SRC_OVC] |=>
		PC_VALUE_O == `ICU_VEC_CNT)
		else $error("counter not preferred over tick");

	AST_RFI_RESTORE: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		RETURN_FROM_INTERRUPT_INSTR_I && state_r == ST_IDLE
		&& !REG_WR_I |=> global_irq_enable_r && STACK_POP_O
		&& PC_VALUE_O == $past(STACKED_PC_I))
		else $error("return from interrupt did not restore");

	AST_RET_KEEP: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		RET_I && !RETURN_FROM_INTERRUPT_INSTR_I && state_r == ST_IDLE
		&& !REG_WR_I |=> STACK_POP_O
		&& global_irq_enable_r == $past(global_irq_enable_r))
		else $error("plain return changed global enable");

	AST_WAKE: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		$rose(flag_r[`ICU_SRC_TICK]) |=> WAKE_O)
		else $error("flag rise gave no wake");

	AST_PUSH_DATA: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take |=> STACK_PUSH_O && STACK_PUSH_DATA_O == $past(NEXT_PC_I)
		##1 !STACK_PUSH_O)
		else $error("wrong return address pushed");

	AST_TICK_SET: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		TICK_OVF_I |=> flag_r[`ICU_SRC_TICK])
		else $error("tick event did not set its flag");

	AST_OVC_SET: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		ovc_rise |=> flag_r[`ICU_SRC_OVC])
		else $error("over-current event did not set its flag");

	AST_DISABLED_KEEP: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		flag_r[`ICU_SRC_CNT] && !en_r[`ICU_SRC_CNT] && !REG_WR_I
		|=> flag_r[`ICU_SRC_CNT])
		else $error("disabled source lost its flag");

	AST_OVC_NEEDS: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		STACK_PUSH_O && PC_VALUE_O == `ICU_VEC_OVC |->
		$past(global_irq_enable_r) && $past(en_r[`ICU_SRC_OVC])
		&& $past(flag_r[`ICU_SRC_OVC]) && !$past(STACK_FULL_I))
		else $error("over-current entry without all conditions");

	AST_TICK_VECTOR: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.grant[`ICU_SRC_TICK] |=>
		PC_VALUE_O == `ICU_VEC_TICK)
		else $error("tick entry used a wrong vector");

	AST_POP_CAUSE: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		STACK_POP_O |->
		$past(RET_I) || $past(RETURN_FROM_INTERRUPT_INSTR_I))
		else $error("stack popped without a return");

	AST_CNT_CLEAR: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.grant[`ICU_SRC_CNT] && !COUNTER_OVF_I |=>
		!flag_r[`ICU_SRC_CNT])
		else $error("counter flag kept after service");

	AST_TICK_CLEAR: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.grant[`ICU_SRC_TICK] && !TICK_OVF_I |=>
		!flag_r[`ICU_SRC_TICK])
		else $error("tick flag kept after service");

	AST_HELD_PENDING: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		STACK_PUSH_O && TICK_OVF_I |=> flag_r[`ICU_SRC_TICK])
		else $error("event during service was lost");

	AST_WAKE_CAUSE: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		WAKE_O |-> ($past(flag_r) & ~$past(flag_r, 2)) != '0)
		else $error("wake without a flag rise");

	AST_TICK_LAST: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		take && arb_bus.pending[`ICU_SRC_TICK]
		&& arb_bus.pending[`ICU_SRC_CNT] |=> PC_VALUE_O != `ICU_VEC_TICK)
		else $error("tick preferred over counter");

	AST_RET_PC: assert property (
		@(posedge CLK_SYS_I) disable iff (RST_I)
		RET_I && state_r == ST_IDLE |=>
		PC_LOAD_O && PC_VALUE_O == $past(STACKED_PC_I))
		else $error("plain return did not load saved address");
endmodule

// ---- icu_regs.svh ----
`ifndef ICU_REGS_SVH
`define ICU_REGS_SVH

// control register field positions
`define ICU_BIT_UNUSED 7
`define ICU_BIT_TICK_FLAG 6
`define ICU_BIT_CNT_FLAG 5
`define ICU_BIT_OVC_FLAG 4
`define ICU_BIT_TICK_EN 3
`define ICU_BIT_CNT_EN 2
`define ICU_BIT_OVC_EN 1
`define ICU_BIT_GLOBAL_EN 0
`define ICU_FLAG_LSB 4
`define ICU_EN_LSB 1
`define ICU_CTRL_RESET 8'h00

// source indices, lowest index is most urgent
`define ICU_NUM_SRC 3
`define ICU_SRC_OVC 0
`define ICU_SRC_CNT 1
`define ICU_SRC_TICK 2

// program counter width and vector addresses
`define ICU_PC_W 12
`define ICU_VEC_OVC 12'h004
`define ICU_VEC_CNT 12'h008
`define ICU_VEC_TICK 12'h00C

`endif

// ---- icu_pkg.sv ----
`include "icu_regs.svh"

package icu_pkg;
	typedef logic [`ICU_PC_W-1:0] pc_t;
	typedef logic [`ICU_NUM_SRC-1:0] src_vec_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ENTRY = 3'b010,
		ST_RETURN = 3'b100
	} ctl_state_t;
endpackage

// ---- irq_arb_if.sv ----
`timescale 1ns/1ns

interface irq_arb_if;
	import icu_pkg::*;
	src_vec_t pending;
	src_vec_t grant;
	pc_t vector;
	logic any;
	modport arb(input pending, output grant, output vector, output any);
	modport ctl(output pending, input grant, input vector, input any);
endinterface

// ---- irq_arbiter.sv ----
`timescale 1ns/1ns
`include "icu_regs.svh"

module irq_arbiter import icu_pkg::*; (
	irq_arb_if.arb bus
);
	src_vec_t higher;

	// each source is granted only when no more urgent one is pending
	genvar i;
	generate
		for (i = 0; i < `ICU_NUM_SRC; i = i + 1) begin : g_prio
			if (i == 0) begin : g_top
				assign higher[i] = 1'b0;
			end else begin : g_rest
				assign higher[i] = higher[i-1] | bus.pending[i-1];
			end
			assign bus.grant[i] = bus.pending[i] & ~higher[i];
		end
	endgenerate

	assign bus.any = |bus.pending;

	always_comb begin
		if (bus.grant[`ICU_SRC_OVC]) begin
			bus.vector = `ICU_VEC_OVC;
		end else if (bus.grant[`ICU_SRC_CNT]) begin
			bus.vector = `ICU_VEC_CNT;
		end else begin
			bus.vector = `ICU_VEC_TICK;
		end
	end
endmodule

// ---- cpu_stack_model.sv ----
`timescale 1ns/1ns

module cpu_stack_model import icu_pkg::*; #(
	parameter int DEPTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire pc_t push_data_i,
	input wire logic pop_i,
	output pc_t top_o,
	output logic full_o
);
	pc_t mem_r [0:7];
	int cnt_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 0;
		end else if (push_i && cnt_r < DEPTH) begin
			mem_r[cnt_r] <= push_data_i;
			cnt_r <= cnt_r + 1;
		end else if (pop_i && cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
		end
	end
	// empty stack shows garbage, not a stale address
	assign top_o = (cnt_r > 0) ? mem_r[cnt_r - 1] : ~mem_r[0];
	assign full_o = cnt_r >= DEPTH;
endmodule

// ---- three_source_interrupt_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin \
	checked++; \
	if ((a) !== (e)) begin \
		errors++; \
		$display("BAD %0t got %h exp %h", $time, a, e); \
	end \
end

module three_source_interrupt_ctrl_tb_top import icu_pkg::*; ();
	logic clk = 0, rst = 1, wr = 0, cnt_ovf = 0, tick_ovf = 0, ovc = 0;
	logic bnd = 0, ret = 0, return_from_interrupt_instr = 0, w;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	pc_t next_pc = 12'h123;
	pc_t push_data, pc_val, top;
	logic pending, push, pop, load, wake, full;
	int errors = 0, checked = 0, cyc = 0;

	three_source_interrupt_ctrl u_three_source_interrupt_ctrl (
		.CLK_SYS_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .COUNTER_OVF_I(cnt_ovf), .TICK_OVF_I(tick_ovf),
		.OVERCURRENT_I(ovc), .INSTR_BOUNDARY_I(bnd), .STACK_FULL_I(full),
		.NEXT_PC_I(next_pc), .STACKED_PC_I(top), .RET_I(ret),
		.RETURN_FROM_INTERRUPT_INSTR_I(return_from_interrupt_instr),
		.IRQ_PENDING_O(pending), .STACK_PUSH_O(push),
		.STACK_PUSH_DATA_O(push_data), .STACK_POP_O(pop),
		.PC_LOAD_O(load), .PC_VALUE_O(pc_val), .WAKE_O(wake));
	// one-deep stack so a single entry fills it
	cpu_stack_model #(.DEPTH(1)) u_cpu_stack_model (
		.clk_i(clk), .rst_i(rst), .push_i(push), .push_data_i(push_data),
		.pop_i(pop), .top_o(top), .full_o(full));

	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		// the whole sequence needs about 60 cycles
		if (cyc == 500) begin
			errors++;
			give_verdict();
		end
	end

	task give_verdict;
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task wr_reg(input logic [7:0] v);
		@(negedge clk) wr = 1;
		wdata = v;
		@(negedge clk) wr = 0;
	endtask

	// wake lands one cycle after the flag rises, which is the edge that samples the event
	task ev(input logic [1:0] k, input logic exp_w);
		@(negedge clk) {tick_ovf, cnt_ovf} = k;
		@(negedge clk) {tick_ovf, cnt_ovf} = 2'b00;
		w = wake;
		@(negedge clk) w = w | wake;
		`CHK(w, exp_w)
	endtask

	task wait_load(input pc_t pc, input logic [7:0] r, input logic [1:0] pp);
		int n;
		n = 0;
		while (load !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHK(pc_val, pc)
		`CHK(rdata, r)
		`CHK({push, pop}, pp)
		@(negedge clk);
	endtask

	task ret_do(input logic i);
		@(negedge clk) ret = !i;
		return_from_interrupt_instr = i;
		@(negedge clk) ret = 0;
		return_from_interrupt_instr = 0;
	endtask

	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		`CHK(rdata, 8'h00)
		wr_reg(8'hFE);
		`CHK(rdata, 8'h7E)
		wr_reg(8'h00);
		bnd = 1;
		ev(2'b01, 1'b1);
		`CHK(rdata, 8'h20)
		ev(2'b01, 1'b0);
		ev(2'b10, 1'b1);
		`CHK(rdata, 8'h60)
		ovc = 1;
		repeat (5) @(negedge clk);
		`CHK(rdata, 8'h70)
		ovc = 0;
		wr_reg(8'h7E);
		`CHK(pending, 1'b0)
		wr_reg(8'h71);
		repeat (2) @(negedge clk);
		`CHK({pending, load}, 2'b00)
		wr_reg(8'h7F);
		wait_load(12'h004, 8'h6E, 2'b10);
		`CHK(push_data, 12'h123)
		ret_do(0);
		wait_load(12'h123, 8'h6E, 2'b01);
		next_pc = 12'h456;
		wr_reg(8'h6F);
		wait_load(12'h008, 8'h4E, 2'b10);
		ev(2'b01, 1'b1);
		`CHK(rdata, 8'h6E)
		wr_reg(8'h6F);
		repeat (3) @(negedge clk);
		`CHK({pending, load, rdata}, 10'h06F)
		ret_do(1);
		wait_load(12'h456, 8'h6F, 2'b01);
		wait_load(12'h008, 8'h4E, 2'b10);
		ret_do(1);
		wait_load(12'h456, 8'h4F, 2'b01);
		wait_load(12'h00C, 8'h0E, 2'b10);
		give_verdict();
	end
endmodule
